// file: hw/fsps_defines.vh
// constants for the flash self-programming sequencer
`ifndef FSPS_DEFINES_VH
`define FSPS_DEFINES_VH

// register offsets
`define FSPS_CTRL_OFS      2'h0
`define FSPS_LOCK_OFS      2'h1

// control/status fields
`define FSPS_BIT_EN        0
`define FSPS_BIT_ERASE     1
`define FSPS_BIT_WRITE     2
`define FSPS_BIT_LOCK      3
`define FSPS_BIT_REEN      4
`define FSPS_BIT_BUSY      6
`define FSPS_BIT_IE        7

// accepted command codes in the low five control bits
`define FSPS_CMD_REEN      5'h11
`define FSPS_CMD_LOCK      5'h09
`define FSPS_CMD_WRITE     5'h05
`define FSPS_CMD_ERASE     5'h03
`define FSPS_CMD_LOAD      5'h01

// pointer layout: word in page z[5:1], page index z[12:6]
`define FSPS_WORD_LSB      1
`define FSPS_WORD_MSB      5
`define FSPS_PAGE_LSB      6
`define FSPS_PAGE_MSB      12
`define FSPS_NO_READ_WHILE_WRITE_SECTION_PAGE     7'h60
`define FSPS_LAST_WORD     5'h1f

// fuse and lock read addresses
`define FSPS_Z_FUSE_LOW    16'h0000
`define FSPS_Z_LOCK        16'h0001
`define FSPS_Z_FUSE_EXT    16'h0002
`define FSPS_Z_FUSE_HIGH   16'h0003

// reset values
`define FSPS_CTRL_RST      8'h00
`define FSPS_LOCK_RST      8'hff

// issue windows, in cycles after the control write
`define FSPS_SPM_WIN       3'h4
`define FSPS_LPM_WIN       3'h3
`define FSPS_LPM_MIN       3'h2

// programming time
`define FSPS_PROG_TIME_US  3700
`define FSPS_CLK_KHZ       20000
`define FSPS_PROG_CYCLES   ((`FSPS_PROG_TIME_US * `FSPS_CLK_KHZ + 999) / 1000)

`endif

// file: hw/fsps_page_buf.v
// temporary page buffer storage, 32 words of 16 bits, registered read
`timescale 1ns/1ps
`default_nettype none
module fsps_page_buf (
  input  wire        core_clk,
  input  wire        wr_en,
  input  wire [4:0]  wr_addr,
  input  wire [15:0] wr_data,
  input  wire [4:0]  rd_addr,
  output reg  [15:0] rd_data
);

  reg [15:0] mem [0:31];

  always @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule
`default_nettype wire

// file: hw/fsps_sequencer.v
// flash self-programming sequencer: control register, page buffer, fuse and lock reads
//
// Summary of operation
// R1 - erase needs code 00011 then store within four
// R2 - erase uses only the page index field
// R3 - halt core when targeting no-read-while-write section
// R4 - load code stores data pair at word slot
// R5 - buffer clears on write done, reenable, reset
// R6 - software loads each buffer word only once
// R7 - eeprom write during loading discards buffer
// R8 - write code 00101 programs buffer into page
// R9 - software zeroes pointer bits outside page field
// R10 - target address latched when operation starts
// R11 - software uses same page for erase, write
// R12 - interrupt request while enabled and enable low
// R13 - erase or write blocks section, busy set
// R14 - software reenables section after programming completes
// R15 - lock code 01001 takes lock data, no pointer
// R16 - zero in lock data bits 5..2 programs
// R17 - lock programming leaves whole flash readable
// R18 - eeprom write blocks programming and fuse reads
// R19 - pointer 0x0001 armed load returns lock bits
// R20 - armed bits clear on read or timeout
// R21 - pointers 0,3,2 return fuse low, high, extended
// R22 - programmed bits read zero, unprogrammed one
// R23 - enable opens four cycle window, stays high busy
// R24 - other low five bit codes are ignored
// R25 - page load clears section busy flag
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "fsps_defines.vh"
module fsps_sequencer #(
  parameter [16:0] PROG_CYCLES = `FSPS_PROG_CYCLES
) (
  input  wire        core_clk,
  input  wire        nrst,
  input  wire [1:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  input  wire [15:0] z_ptr,
  input  wire [7:0]  data_low_reg,
  input  wire [7:0]  data_high_reg,
  input  wire        spm_stb,
  input  wire        lpm_stb,
  input  wire        eeprom_write_busy,
  input  wire [7:0]  fuse_low_byte,
  input  wire [7:0]  fuse_high_byte,
  input  wire [7:0]  fuse_extended_byte,
  output reg         lpm_hit,
  output reg  [7:0]  lpm_rdata,
  output wire        spm_irq,
  output wire        cpu_halt,
  output wire        rww_read_block,
  output reg         pgm_erase_start,
  output reg         pgm_write_start,
  output reg         pgm_lock_start,
  output reg  [6:0]  pgm_page,
  output reg         pgm_word_valid,
  output reg  [4:0]  pgm_word_idx,
  output wire [15:0] pgm_word_data,
  output reg         pgm_word_loaded,
  output wire [7:0]  boot_lock_bits
);

  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_ARM  = 4'b0010;
  localparam [3:0] ST_XFER = 4'b0100;
  localparam [3:0] ST_BUSY = 4'b1000;

  localparam [16:0] PROG_LAST = PROG_CYCLES - 17'h1;

  reg  [3:0]  state_r;
  reg  [7:0]  ctrl_r;
  reg  [2:0]  win_r;
  reg  [16:0] timer_r;
  reg  [4:0]  xfer_cnt_r;
  reg  [31:0] loaded_r;
  reg         halt_r;
  reg         eep_busy_d_r;
  reg  [7:0]  lock_r;

  wire [4:0]  cmd = ctrl_r[4:0];
  wire [4:0]  wr_cmd = reg_wdata[4:0];
  wire        ctrl_wr = reg_wr && (reg_addr == `FSPS_CTRL_OFS);
  wire        section_busy = ctrl_r[`FSPS_BIT_BUSY];
  wire [4:0]  z_word = z_ptr[`FSPS_WORD_MSB:`FSPS_WORD_LSB];
  wire [6:0]  z_page = z_ptr[`FSPS_PAGE_MSB:`FSPS_PAGE_LSB];
  wire        op_active = (state_r == ST_XFER) || (state_r == ST_BUSY);

  // a command is taken only when it is one of the five codes
  wire        cmd_known = (wr_cmd == `FSPS_CMD_REEN) ||
                          (wr_cmd == `FSPS_CMD_LOCK) ||
                          (wr_cmd == `FSPS_CMD_WRITE) ||
                          (wr_cmd == `FSPS_CMD_ERASE) ||
                          (wr_cmd == `FSPS_CMD_LOAD); // R24

  // arming is refused while the eeprom writes or an operation runs
  wire        arm_req = ctrl_wr && cmd_known && !eeprom_write_busy && !op_active; // R18
  wire        spm_take = (state_r == ST_ARM) && spm_stb && (win_r != 3'h0) &&
                         !eeprom_write_busy; // R1
  wire        lpm_armed = (state_r == ST_ARM) && (cmd == `FSPS_CMD_LOCK) &&
                          (win_r >= `FSPS_LPM_MIN) && !eeprom_write_busy; // R19
  wire        lpm_fuse_addr = (z_ptr == `FSPS_Z_FUSE_LOW) || (z_ptr == `FSPS_Z_LOCK) ||
                              (z_ptr == `FSPS_Z_FUSE_EXT) || (z_ptr == `FSPS_Z_FUSE_HIGH);
  wire        lpm_take = lpm_armed && lpm_stb && lpm_fuse_addr;
  wire        load_take = spm_take && (cmd == `FSPS_CMD_LOAD);
  wire        timer_done = (state_r == ST_BUSY) && (timer_r == PROG_LAST);
  wire        eep_rise = eeprom_write_busy && !eep_busy_d_r;

  fsps_page_buf u_buf (
    .core_clk (core_clk),
    .wr_en    (load_take), // R4
    .wr_addr  (z_word),
    .wr_data  ({data_high_reg, data_low_reg}),
    .rd_addr  (xfer_cnt_r),
    .rd_data  (pgm_word_data)
  );

  // sequencer
  always @(posedge core_clk) begin
    if (!nrst) begin
      state_r         <= ST_IDLE;
      ctrl_r          <= `FSPS_CTRL_RST;
      win_r           <= 3'h0;
      timer_r         <= 17'h0;
      xfer_cnt_r      <= 5'h0;
      halt_r          <= 1'b0;
      pgm_page        <= 7'h0;
      pgm_erase_start <= 1'b0;
      pgm_write_start <= 1'b0;
      pgm_lock_start  <= 1'b0;
      lock_r          <= `FSPS_LOCK_RST;
    end else begin
      pgm_erase_start <= 1'b0;
      pgm_write_start <= 1'b0;
      pgm_lock_start  <= 1'b0;
      if (ctrl_wr) begin
        ctrl_r[`FSPS_BIT_IE] <= reg_wdata[`FSPS_BIT_IE];
      end
      case (state_r)
        ST_IDLE: begin
          if (arm_req) begin
            ctrl_r[4:0] <= wr_cmd;
            win_r       <= `FSPS_SPM_WIN; // R23
            state_r     <= ST_ARM;
          end
        end
        ST_ARM: begin
          if (arm_req) begin
            ctrl_r[4:0] <= wr_cmd;
            win_r       <= `FSPS_SPM_WIN;
          end else if (spm_take) begin
            if (cmd == `FSPS_CMD_ERASE || cmd == `FSPS_CMD_WRITE) begin
              // only the page field is used; later pointer changes do not matter
              pgm_page <= z_page; // R2 R10
              halt_r   <= (z_page >= `FSPS_NO_READ_WHILE_WRITE_SECTION_PAGE); // R3
              ctrl_r[`FSPS_BIT_BUSY] <= 1'b1; // R13
            end
            if (cmd == `FSPS_CMD_ERASE) begin
              pgm_erase_start <= 1'b1; // R1
              timer_r         <= 17'h0;
              state_r         <= ST_BUSY;
            end else if (cmd == `FSPS_CMD_WRITE) begin
              xfer_cnt_r <= 5'h0; // R8
              state_r    <= ST_XFER;
            end else if (cmd == `FSPS_CMD_LOCK) begin
              // zeros in bits 5..2 program, ones leave the bit alone
              lock_r[5:2]    <= lock_r[5:2] & data_low_reg[5:2]; // R15 R16
              pgm_lock_start <= 1'b1;
              halt_r         <= 1'b0; // R17
              timer_r        <= 17'h0;
              state_r        <= ST_BUSY;
            end else begin
              if (cmd == `FSPS_CMD_LOAD) begin
                ctrl_r[`FSPS_BIT_BUSY] <= 1'b0; // R25
              end else begin
                ctrl_r[`FSPS_BIT_BUSY] <= 1'b0; // R14
              end
              ctrl_r[4:0] <= 5'h00; // R23
              win_r       <= 3'h0;
              state_r     <= ST_IDLE;
            end
          end else if (lpm_take) begin
            ctrl_r[4:0] <= 5'h00; // R20
            win_r       <= 3'h0;
            state_r     <= ST_IDLE;
          end else if (win_r == 3'h1) begin
            ctrl_r[4:0] <= 5'h00; // R20 R23
            win_r       <= 3'h0;
            state_r     <= ST_IDLE;
          end else begin
            win_r <= win_r - 3'h1;
          end
        end
        ST_XFER: begin
          // buffer words stream out; the last word goes out together with the write start
          xfer_cnt_r <= xfer_cnt_r + 5'h1;
          if (xfer_cnt_r == `FSPS_LAST_WORD) begin
            pgm_write_start <= 1'b1;
            timer_r         <= 17'h0;
            state_r         <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          // enable stays high for the whole operation
          if (timer_done) begin
            ctrl_r[4:0] <= 5'h00; // R23
            halt_r      <= 1'b0;
            state_r     <= ST_IDLE;
          end else begin
            timer_r <= timer_r + 17'h1;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // slot occupancy; cleared slots program as erased words
  always @(posedge core_clk) begin
    if (!nrst) begin
      loaded_r     <= 32'h0; // R5
      eep_busy_d_r <= 1'b0;
    end else begin
      eep_busy_d_r <= eeprom_write_busy;
      if (timer_done && (cmd == `FSPS_CMD_WRITE)) begin
        loaded_r <= 32'h0; // R5
      end else if (arm_req && (wr_cmd == `FSPS_CMD_REEN)) begin
        loaded_r <= 32'h0; // R5
      end else if (eep_rise) begin
        loaded_r <= 32'h0; // R7
      end else if (load_take) begin
        loaded_r[z_word] <= 1'b1; // R4
      end
    end
  end

  // word stream to the array, aligned with the registered buffer read
  always @(posedge core_clk) begin
    if (!nrst) begin
      pgm_word_valid  <= 1'b0;
      pgm_word_idx    <= 5'h0;
      pgm_word_loaded <= 1'b0;
    end else begin
      pgm_word_valid  <= (state_r == ST_XFER);
      pgm_word_idx    <= xfer_cnt_r;
      pgm_word_loaded <= loaded_r[xfer_cnt_r];
    end
  end

  // fuse and lock readback, bits show raw: programmed reads zero
  always @(posedge core_clk) begin
    if (!nrst) begin
      lpm_hit   <= 1'b0;
      lpm_rdata <= 8'h00;
    end else begin
      lpm_hit <= lpm_take;
      if (lpm_take) begin
        if (z_ptr == `FSPS_Z_LOCK) begin
          lpm_rdata <= lock_r; // R19 R22
        end else if (z_ptr == `FSPS_Z_FUSE_LOW) begin
          lpm_rdata <= fuse_low_byte; // R21 R22
        end else if (z_ptr == `FSPS_Z_FUSE_HIGH) begin
          lpm_rdata <= fuse_high_byte; // R21
        end else begin
          lpm_rdata <= fuse_extended_byte; // R21
        end
      end
    end
  end

  // register read port
  always @(posedge core_clk) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == `FSPS_CTRL_OFS) begin
        reg_rdata <= {ctrl_r[7:6], 1'b0, ctrl_r[4:0]};
      end else if (reg_addr == `FSPS_LOCK_OFS) begin
        reg_rdata <= lock_r;
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  assign spm_irq        = ctrl_r[`FSPS_BIT_IE] && !ctrl_r[`FSPS_BIT_EN]; // R12
  assign cpu_halt       = op_active && halt_r; // R3
  assign rww_read_block = section_busy; // R13
  assign boot_lock_bits = lock_r;

endmodule
`default_nettype wire

// file: verif/flash_self_programming_sequencer_tb_top.sv
// self-checking bench for the flash self-programming sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_self_programming_sequencer_tb_top;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        eeprom_write_busy = 1'b0;
  logic [1:0]  reg_addr = 2'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  fuse_low_byte, fuse_high_byte, fuse_extended_byte, reg_rdata, lpm_rdata;
  logic [7:0]  boot_lock_bits, data_low_reg, data_high_reg;
  logic [15:0] z_ptr, pgm_word_data, d;
  logic [6:0]  pgm_page, wpage;
  logic [4:0]  pgm_word_idx;
  logic        spm_stb, lpm_stb, lpm_hit, spm_irq, cpu_halt, rww_read_block;
  logic        pgm_erase_start, pgm_lock_start, pgm_word_valid, pgm_word_loaded, pgm_write_start;
  logic [31:0] seed = 32'h346cee75;
  int          miscompares = 0, n_compared = 0, n_words = 0, lock_m = 255, i, w;
  int          buf_m [32];
  always #25 core_clk = ~core_clk;
  fsps_core_model u_core (.core_clk, .z_ptr, .data_low_reg, .data_high_reg, .spm_stb, .lpm_stb);
  fsps_sequencer #(.PROG_CYCLES(17'd20)) u_dut (.core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .z_ptr, .data_low_reg, .data_high_reg, .spm_stb, .lpm_stb,
    .eeprom_write_busy, .fuse_low_byte, .fuse_high_byte, .fuse_extended_byte, .lpm_hit,
    .lpm_rdata, .spm_irq, .cpu_halt, .rww_read_block, .pgm_erase_start, .pgm_write_start,
    .pgm_lock_start, .pgm_page, .pgm_word_valid, .pgm_word_idx, .pgm_word_data,
    .pgm_word_loaded, .boot_lock_bits);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(reg_rdata, exp);
  endtask
  task automatic cmd(input logic [7:0] c, input int gap, input logic [15:0] z, input logic e);
    wr(2'h0, c);
    u_core.store(gap, z, d);
    @(negedge core_clk);
    chk(pgm_erase_start, e);
  endtask
  task end_sim;
    if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    if (nrst && pgm_word_valid) begin
      n_words++;
      chk(pgm_word_loaded, buf_m[pgm_word_idx] >= 0);
      if (buf_m[pgm_word_idx] >= 0) chk(pgm_word_data, buf_m[pgm_word_idx][15:0]);
      chk(pgm_page, wpage);
      chk(pgm_write_start, pgm_word_idx == 5'h1f);
    end
  end
  initial begin
    #500000;
    miscompares++;
    end_sim();
  end
  initial begin
    for (i = 0; i < 32; i++) buf_m[i] = -1;
    {fuse_low_byte, fuse_high_byte, fuse_extended_byte} = 24'(rnd());
    d = 16'(rnd());
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    rd(2'h0, 8'h00);
    rd(2'h1, 8'hff);
    rd(2'h2, 8'h00);
    for (i = 0; i < 5; i++) begin
      wr(2'h0, 8'h09);
      u_core.load(i == 4 ? 3 : i % 3, 16'(i % 4), 1);
      @(negedge core_clk);
      chk(lpm_hit, i < 4);
      if (i < 4) chk(lpm_rdata, i == 0 ? fuse_low_byte : i == 1 ? 8'hff : i == 2 ? fuse_extended_byte : fuse_high_byte);
      rd(2'h0, 8'h00);
    end
    wr(2'h0, 8'h09);
    u_core.load(0, 16'h0001, 2);
    @(negedge core_clk);
    chk(lpm_hit, 1'b0);
    cmd(8'h07, 0, 16'h0c20, 1'b0);
    cmd(8'h83, 1, {3'h5, 7'h61, 5'h05, 1'b1}, 1'b1);
    chk(pgm_page, 7'h61);
    chk(cpu_halt, 1'b1);
    chk(spm_irq, 1'b0);
    rd(2'h0, 8'hc3);
    repeat (30) @(posedge core_clk);
    rd(2'h0, 8'hc0);
    chk(spm_irq, 1'b1);
    cmd(8'h11, 0, 16'h0000, 1'b0);
    rd(2'h0, 8'h00);
    cmd(8'h03, 4, {3'h0, 7'h05, 6'h00}, 1'b0);
    cmd(8'h03, 3, {3'h0, 7'h05, 6'h00}, 1'b1);
    chk(cpu_halt, 1'b0);
    repeat (30) @(posedge core_clk);
    rd(2'h0, 8'h40);
    for (i = 0; i < 3; i++) begin
      d = 16'(rnd());
      w = (i * 14 + 3) % 32;
      buf_m[w] = d;
      cmd(8'h01, 3 - i, {3'h0, 7'h05, 5'(w), 1'b0}, 1'b0);
      rd(2'h0, 8'h00);
    end
    wpage = 7'h05;
    cmd(8'h05, 0, {3'h0, wpage, 6'h00}, 1'b0);
    repeat (70) @(posedge core_clk);
    chk(16'(n_words), 16'd32);
    rd(2'h0, 8'h40);
    for (i = 0; i < 32; i++) buf_m[i] = -1;
    cmd(8'h01, 0, {3'h0, 7'h09, 5'h07, 1'b0}, 1'b0);
    @(posedge core_clk);
    eeprom_write_busy <= 1'b1;
    cmd(8'h03, 0, {3'h0, 7'h09, 6'h00}, 1'b0);
    rd(2'h0, 8'h00);
    @(posedge core_clk);
    eeprom_write_busy <= 1'b0;
    wpage = 7'h09;
    cmd(8'h05, 0, {3'h0, wpage, 6'h00}, 1'b0);
    repeat (70) @(posedge core_clk);
    chk(16'(n_words), 16'd64);
    d = 16'(rnd());
    lock_m = lock_m & (d[7:0] | 8'hc3);
    wr(2'h0, 8'h09);
    u_core.store(2, 16'(rnd()), d);
    @(negedge core_clk);
    chk(pgm_lock_start, 1'b1);
    chk(cpu_halt, 1'b0);
    repeat (30) @(posedge core_clk);
    rd(2'h1, lock_m[7:0]);
    wr(2'h0, 8'h09);
    u_core.load(0, 16'h0001, 1);
    @(negedge core_clk);
    chk(lpm_rdata, lock_m[7:0]);
    end_sim();
  end
endmodule
`default_nettype wire

// file: verif/fsps_asserts.sv
// port assertions for the flash self-programming sequencer
`timescale 1ns/1ps
`default_nettype none
module fsps_asserts (
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        reg_wr,
  input wire logic [15:0] z_ptr,
  input wire logic        spm_stb,
  input wire logic        lpm_stb,
  input wire logic        eeprom_write_busy,
  input wire logic [7:0]  fuse_low_byte,
  input wire logic [7:0]  fuse_high_byte,
  input wire logic [7:0]  fuse_extended_byte,
  input wire logic        lpm_hit,
  input wire logic [7:0]  lpm_rdata,
  input wire logic        cpu_halt,
  input wire logic        rww_read_block,
  input wire logic        pgm_erase_start,
  input wire logic        pgm_lock_start,
  input wire logic [6:0]  pgm_page,
  input wire logic [7:0]  boot_lock_bits
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  erase_cause_a: assert property (pgm_erase_start |-> $past(spm_stb))
    else $error("erase start without store");
  busy_erase_a: assert property (pgm_erase_start |-> rww_read_block)
    else $error("busy flag low at erase");
  no_read_while_write_section_halt_a: assert property (pgm_erase_start |-> cpu_halt == (pgm_page >= 7'h60))
    else $error("halt does not follow page");
  ee_block_a: assert property (eeprom_write_busy && spm_stb |=> !pgm_erase_start && !pgm_lock_start)
    else $error("operation started during eeprom write");
  lock_readable_a: assert property (pgm_lock_start |-> !cpu_halt)
    else $error("halt during lock set");
  lock_keep_a: assert property (pgm_lock_start |=> boot_lock_bits[7:6] == 2'h3 && boot_lock_bits[1:0] == 2'h3)
    else $error("lock bits outside 5..2 changed");
  lpm_value_a: assert property (lpm_hit |-> lpm_rdata == ($past(z_ptr[1:0]) == 2'h1 ? boot_lock_bits
    : $past(z_ptr[1:0]) == 2'h0 ? fuse_low_byte
    : $past(z_ptr[1:0]) == 2'h3 ? fuse_high_byte : fuse_extended_byte)) else $error("wrong fuse value");
  lpm_once_a: assert property (lpm_hit && lpm_stb && !reg_wr && !$past(reg_wr) |=> !lpm_hit)
    else $error("second load still armed");
endmodule
bind fsps_sequencer fsps_asserts u_chk (.core_clk, .nrst, .reg_wr, .z_ptr, .spm_stb, .lpm_stb,
  .eeprom_write_busy, .fuse_low_byte, .fuse_high_byte, .fuse_extended_byte, .lpm_hit, .lpm_rdata,
  .cpu_halt, .rww_read_block, .pgm_erase_start, .pgm_lock_start, .pgm_page, .boot_lock_bits);
`default_nettype wire

// file: verif/fsps_core_model.sv
// processor core model issuing store and load instructions
`timescale 1ns/1ps
`default_nettype none
module fsps_core_model (
  input  wire logic        core_clk,
  output var  logic [15:0] z_ptr,
  output var  logic [7:0]  data_low_reg,
  output var  logic [7:0]  data_high_reg,
  output var  logic        spm_stb,
  output var  logic        lpm_stb
);
  initial begin
    {z_ptr, data_high_reg, data_low_reg, spm_stb, lpm_stb} = 34'h0;
  end
  task automatic store(input int gap, input logic [15:0] z, input logic [15:0] d);
    repeat (gap) @(posedge core_clk);
    spm_stb <= 1'b1;
    z_ptr <= z;
    {data_high_reg, data_low_reg} <= d;
    @(posedge core_clk);
    spm_stb <= 1'b0;
    z_ptr <= ~z;
    {data_high_reg, data_low_reg} <= ~d;
  endtask
  task automatic load(input int gap, input logic [15:0] z, input int n);
    repeat (gap) @(posedge core_clk);
    lpm_stb <= 1'b1;
    z_ptr <= z;
    repeat (n) @(posedge core_clk);
    lpm_stb <= 1'b0;
    z_ptr <= ~z;
  endtask
endmodule
`default_nettype wire
